//--- bbms_pkg.sv
/*
 * Shared constants for the pixel block move mask sequencer.
 * Assumes four 8-bit pixels per 32-bit memory word.
 */
package bbms_pkg;
    // ==========================================================
    // Word layout
    localparam int PIX_W        = 8;
    localparam int PIX_PER_WORD = 4;
    localparam int WORD_W       = 32;
    localparam int LSB_W        = 2;
    // ==========================================================
    // Fixed masks and write FIFO depth
    localparam logic [3:0] MASK_ALL  = 4'hF;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam int FIFO_DEPTH = 4;
    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_FIRST  = 5'h02,
        ST_SECOND = 5'h04,
        ST_MIDDLE = 5'h08,
        ST_END    = 5'h10
    } bbms_state_type;
endpackage : bbms_pkg

//--- bbms_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bbms_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("DEPTH must be a power of two of at least 2");
    end
    // ==========================================================
    // State
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } bbms_fifo_type;
    bbms_fifo_type s_reg, s_next;
    logic push, pop;
    always_comb begin
        s_next = s_reg;
        push   = wr_valid_in && (s_reg.cnt != (AW+1)'(DEPTH));
        pop    = rd_ready_in && (s_reg.cnt != '0);
        if (push) begin
            s_next.mem[s_reg.wp] = wr_data_in;
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign wr_ready_out = (s_reg.cnt != (AW+1)'(DEPTH));
    assign rd_valid_out = (s_reg.cnt != '0);
    assign rd_data_out  = s_reg.mem[s_reg.rp];
endmodule : bbms_fifo
`default_nettype wire

//--- bbms_sequencer.sv
/*
 * Pixel block move sequencer: derives shift, write-enable masks, serial
 * clock masks and column advance for a move from the serial buffer through
 * the alignment rotator into the random port.
 * Assumes the serial buffer has been loaded by a read transfer beforehand,
 * that serial data arrives on the system clock, and that the memory
 * controller accepts one write per cycle when WR_READY_IN is high.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Software gives source, destination, count.
// R2 - Four 8-bit pixels per word; low bits position.
// R3 - Aligned move: no rotation, no masks.
// R4 - Unaligned move masks start, end or both.
// R5 - Per-pixel write enables preserve untouched pixels.
// R6 - Read transfer preloads serial buffer word-aligned.
// R7 - Writing destination address starts the move.
// R8 - Stages: two start, middle, one ending.
// R9 - Masks except middle; start adds clock masks.
// R10 - Shift equals source minus destination mod four.
// R11 - First cycle column advance only if src<=dst.
// R12 - First write mask from dst to clipped end.
// R13 - First clock mask ones unless src below dst.
// R14 - Second cycle always advances; partial masks if src>dst.
// R15 - Middle cycles write full rotated words.
// R16 - Ending mask enables positions 0..k-1.
// R17 - Moves span rows; rotate within word.
// R18 - Rotation adds exactly one register stage.
// R19 - Refresh may stall; completion is exposed.
// R20 - Busy set from start until ending write.
module bbms_sequencer #(
    parameter int CNT_W = 20
) (
    input  wire logic                         MCLK_IN,
    input  wire logic                         RST_IN,
    input  wire logic [1:0]                   SRC_LSB_IN,
    input  wire logic [1:0]                   DST_LSB_IN,
    input  wire logic [CNT_W-1:0]             PIXEL_COUNT_IN,
    input  wire logic                         DST_WRITE_IN,
    input  wire logic                         HOLD_IN,
    input  wire logic [bbms_pkg::WORD_W-1:0]  SERIAL_DATA_IN,
    input  wire logic                         WR_READY_IN,
    output logic                              BUSY_OUT,
    output logic                              DONE_OUT,
    output logic [1:0]                        SHIFT_OUT,
    output logic [3:0]                        SERIAL_CLOCK_MASK_OUT,
    output logic                              COLUMN_ADVANCE_ENABLE_OUT,
    output logic [bbms_pkg::WORD_W-1:0]       WR_DATA_OUT,
    output logic [3:0]                        WR_ENABLE_OUT,
    output logic                              WR_VALID_OUT
);
    localparam int OCC_W = $clog2(bbms_pkg::FIFO_DEPTH) + 1;
    if (CNT_W < 3) begin : g_cnt_check
        $error("CNT_W too small");
    end
    // ==========================================================
    // State record
    typedef struct packed {
        bbms_pkg::bbms_state_type    st;
        logic [1:0]                  src;
        logic [1:0]                  dst;
        logic [1:0]                  shift;
        logic [1:0]                  cnt_lsb;
        logic [CNT_W-1:0]            words;
        logic                        single;
        logic                        busy;
        logic                        done;
        logic [3:0]                  sclk_mask;
        logic                        col_adv;
        logic [bbms_pkg::WORD_W-1:0] rot_data;
        logic [3:0]                  rot_we;
        logic                        rot_valid;
        logic [3:0]                  pend_we;
        logic                        pend_valid;
        logic [OCC_W-1:0]            occ;
    } bbms_seq_type;
    bbms_seq_type s_reg, s_next;
    // ==========================================================
    // Mask and rotation functions; bit 3 of a mask is pixel position 0.
    function automatic logic [3:0] pos_mask(input logic [2:0] lo, input logic [2:0] hi);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) >= lo && 3'(i) <= hi) m[3-i] = 1'b1;
        end
        return m;
    endfunction : pos_mask
    function automatic logic [31:0] rotate(input logic [31:0] w, input logic [1:0] sh);
        logic [63:0] d;
        d = {w, w} << (sh * 8);
        return d[63:32];
    endfunction : rotate
    // ==========================================================
    // Combinational sequencing
    logic [2:0]  first_hi;
    logic [3:0]  first_we;
    logic [3:0]  first_sclk;
    logic [3:0]  second_we;
    logic [3:0]  end_we;
    logic [1:0]  last_pos;
    logic [CNT_W+1:0] span;
    logic        step;
    logic [3:0]  we;
    logic        emit;
    logic        fifo_ready;
    logic        fifo_valid;
    logic [31:0] fifo_data;
    logic        fifo_pop;
    always_comb begin
        s_next    = s_reg;
        emit      = 1'b0;
        we        = bbms_pkg::MASK_NONE;
        // Write end position of first word: dst + 3 - src, clipped at three.
        first_hi  = 3'(({1'b0, s_reg.dst} + 3'd3 > {1'b0, s_reg.src}) ?
                    ({1'b0, s_reg.dst} + 3'd3 - {1'b0, s_reg.src}) : 3'd0);
        if (first_hi > 3'd3) first_hi = 3'd3;
        first_we  = pos_mask({1'b0, s_reg.dst}, first_hi);                    // [R12]
        first_sclk = (s_reg.src >= s_reg.dst) ? bbms_pkg::MASK_ALL :          // [R13]
                     pos_mask(3'd0, 3'(3'd3 - ({1'b0, s_reg.dst} - {1'b0, s_reg.src})));
        second_we = (s_reg.src > s_reg.dst) ?                                 // [R14]
                    pos_mask(3'(3'd4 - ({1'b0, s_reg.src} - {1'b0, s_reg.dst})), 3'd3) :
                    bbms_pkg::MASK_ALL;
        last_pos  = 2'(s_reg.dst + s_reg.cnt_lsb - 2'd1);
        end_we    = pos_mask(3'd0, {1'b0, last_pos});                         // [R16]
        // Words in flight are counted, so the two stages ahead of the FIFO can never overrun it.
        step      = !HOLD_IN && fifo_ready && (s_reg.occ < OCC_W'(bbms_pkg::FIFO_DEPTH)); // [R19]
        s_next.sclk_mask = bbms_pkg::MASK_NONE;
        s_next.col_adv   = 1'b0;
        s_next.done      = 1'b0;
        span = '0;
        case (s_reg.st)
            bbms_pkg::ST_IDLE: begin
                if (DST_WRITE_IN && PIXEL_COUNT_IN != '0) begin                // [R1] [R7]
                    s_next.src     = SRC_LSB_IN;                               // [R2]
                    s_next.dst     = DST_LSB_IN;
                    s_next.shift   = 2'(SRC_LSB_IN - DST_LSB_IN);              // [R10]
                    s_next.cnt_lsb = PIXEL_COUNT_IN[1:0];
                    // Destination words touched, counting the partial ones.
                    span = (CNT_W+2)'(PIXEL_COUNT_IN) + (CNT_W+2)'(DST_LSB_IN) + (CNT_W+2)'(3);
                    s_next.words   = CNT_W'(span >> 2);
                    s_next.single  = (span >> 2) == (CNT_W+2)'(1);
                    s_next.busy    = 1'b1;                                     // [R20]
                    s_next.st      = bbms_pkg::ST_FIRST;
                end
            end
            bbms_pkg::ST_FIRST: begin
                if (step) begin
                    s_next.sclk_mask = first_sclk;                             // [R9]
                    s_next.col_adv   = (s_reg.src <= s_reg.dst);               // [R11]
                    we   = s_reg.single ? (first_we & end_we) : first_we;      // [R5]
                    emit = 1'b1;
                    s_next.st = bbms_pkg::ST_SECOND;
                end
            end
            bbms_pkg::ST_SECOND: begin
                if (step) begin
                    s_next.sclk_mask = (s_reg.src > s_reg.dst) ?               // [R14]
                                       pos_mask(3'd0, 3'({1'b0, s_reg.src} - {1'b0, s_reg.dst} - 3'd1)) :
                                       bbms_pkg::MASK_ALL;
                    s_next.col_adv   = 1'b1;
                    // When the first word was written in the first cycle, this is the next word.
                    we   = (s_reg.words == CNT_W'(2) && s_reg.src <= s_reg.dst) ? end_we :
                           (s_reg.single ? (second_we & end_we) : second_we);
                    // A single word with src above dst is finished here, in its second write.
                    emit = !s_reg.single || (s_reg.src > s_reg.dst);
                    if (s_reg.single) begin
                        s_next.st = bbms_pkg::ST_END;
                    end else begin
                        s_next.words = s_reg.words - ((s_reg.src <= s_reg.dst) ? CNT_W'(2) : CNT_W'(1));
                        s_next.st = (s_next.words <= CNT_W'(1)) ? bbms_pkg::ST_END :
                                    bbms_pkg::ST_MIDDLE;                        // [R8]
                        if (s_next.words == '0) s_next.st = bbms_pkg::ST_END;
                    end
                end
            end
            bbms_pkg::ST_MIDDLE: begin
                if (step) begin
                    s_next.sclk_mask = bbms_pkg::MASK_ALL;                     // [R15]
                    s_next.col_adv   = 1'b1;
                    we   = bbms_pkg::MASK_ALL;
                    emit = 1'b1;
                    s_next.words = s_reg.words - CNT_W'(1);
                    if (s_next.words == CNT_W'(1)) s_next.st = bbms_pkg::ST_END;
                end
            end
            bbms_pkg::ST_END: begin
                if (step) begin
                    if (s_reg.words == CNT_W'(1) && !s_reg.single &&
                        !(s_reg.src <= s_reg.dst && s_reg.words == '0)) begin
                        // No serial clock or column step: nothing follows this word.
                        we   = end_we;                                         // [R4] [R16]
                        emit = 1'b1;
                    end
                    s_next.busy = 1'b0;                                        // [R20]
                    s_next.done = 1'b1;
                    s_next.st   = bbms_pkg::ST_IDLE;
                end
            end
            default: begin
                s_next = '0;
                s_next.st = bbms_pkg::ST_IDLE;
            end
        endcase
        // Aligned moves keep shift zero, so rotation and masks are identity.  [R3]
        // A stage's serial clock reaches the memory one cycle late, so its word is taken
        // one cycle after the stage, once the previous stage's clock has acted.
        s_next.pend_valid = emit;
        s_next.pend_we    = we;
        s_next.rot_valid  = s_reg.pend_valid;
        s_next.rot_we     = s_reg.pend_we;
        s_next.rot_data   = rotate(SERIAL_DATA_IN, s_reg.shift);              // [R17] [R18]
        if (emit && !(fifo_valid && fifo_pop)) begin
            s_next.occ = s_reg.occ + 1'b1;
        end else if (!emit && fifo_valid && fifo_pop) begin
            s_next.occ = s_reg.occ - 1'b1;
        end
    end
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_reg    <= '0;
            s_reg.st <= bbms_pkg::ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end
    // ==========================================================
    // Write FIFO; a full FIFO stalls the sequencer through step.
    logic [35:0] fifo_out;
    assign fifo_pop = WR_READY_IN;
    bbms_fifo #(
        .WIDTH (36),
        .DEPTH (bbms_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (MCLK_IN),
        .rst_in       (RST_IN),
        .wr_data_in   ({s_reg.rot_we, s_reg.rot_data}),                      // [R5]
        .wr_valid_in  (s_reg.rot_valid),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (fifo_out),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_pop)
    );
    assign fifo_data = fifo_out[31:0];
    // ==========================================================
    // Output registers
    typedef struct packed {
        logic [31:0] d;
        logic [3:0]  we;
        logic        v;
    } bbms_out_type;
    bbms_out_type o_reg, o_next;
    always_comb begin
        o_next    = '0;
        o_next.v  = fifo_valid && fifo_pop;
        o_next.d  = fifo_data;
        o_next.we = fifo_out[35:32];
    end
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            o_reg <= '0;
        end else begin
            o_reg <= o_next;
        end
    end
    assign BUSY_OUT                  = s_reg.busy;
    assign DONE_OUT                  = s_reg.done;
    assign SHIFT_OUT                 = s_reg.shift;
    assign SERIAL_CLOCK_MASK_OUT     = s_reg.sclk_mask;
    assign COLUMN_ADVANCE_ENABLE_OUT = s_reg.col_adv;
    assign WR_DATA_OUT               = o_reg.d;
    assign WR_ENABLE_OUT             = o_reg.we;
    assign WR_VALID_OUT              = o_reg.v;
endmodule : bbms_sequencer
`default_nettype wire

//--- bbms_sequencer_assertions.sv
/*
 * Concurrent checks on the ports of the pixel block move sequencer.
 * Assumes one clock domain and the asynchronous active-high reset of the design.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module bbms_sequencer_assertions #(
    parameter int CNT_W = 20
) (
    input wire logic             MCLK_IN,
    input wire logic             RST_IN,
    input wire logic [1:0]       SRC_LSB_IN,
    input wire logic [1:0]       DST_LSB_IN,
    input wire logic [CNT_W-1:0] PIXEL_COUNT_IN,
    input wire logic             DST_WRITE_IN,
    input wire logic             HOLD_IN,
    input wire logic             BUSY_OUT,
    input wire logic             DONE_OUT,
    input wire logic [1:0]       SHIFT_OUT,
    input wire logic [3:0]       SERIAL_CLOCK_MASK_OUT,
    input wire logic             COLUMN_ADVANCE_ENABLE_OUT,
    input wire logic [3:0]       WR_ENABLE_OUT,
    input wire logic             WR_VALID_OUT
);
    logic       start_now;
    logic [1:0] shift_exp_reg;
    logic       aligned_reg;
    assign start_now = DST_WRITE_IN && !BUSY_OUT && (PIXEL_COUNT_IN != '0);
    // The move's parameters are kept so late FIFO writes are still judged against their own move.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            shift_exp_reg <= 2'h0;
            aligned_reg   <= 1'b0;
        end else if (start_now) begin
            shift_exp_reg <= SRC_LSB_IN - DST_LSB_IN;
            aligned_reg   <= (SRC_LSB_IN == 2'h0) && (DST_LSB_IN == 2'h0) && (PIXEL_COUNT_IN[1:0] == 2'h0);
        end
    end
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);
    sequence s_start;
        start_now;
    endsequence
    sequence s_run;
        BUSY_OUT ##[1:400] DONE_OUT;
    endsequence
    AST_START_BUSY: assert property (s_start |=> BUSY_OUT)
        else $error("Move start did not raise busy");
    AST_RUN_BOUNDED: assert property (s_start |=> s_run)
        else $error("Move did not complete in time");
    AST_SHIFT_VALUE: assert property ((BUSY_OUT && $past(BUSY_OUT)) |-> SHIFT_OUT == shift_exp_reg)
        else $error("Shift differs from source minus destination");
    AST_REFUSE_BUSY: assert property ((BUSY_OUT && DST_WRITE_IN) |=> $stable(SHIFT_OUT))
        else $error("Start while busy changed the shift");
    AST_DONE_PULSE: assert property (DONE_OUT |=> !DONE_OUT)
        else $error("Completion pulse longer than one cycle");
    AST_DONE_ENDS_BUSY: assert property ($fell(BUSY_OUT) |-> DONE_OUT)
        else $error("Busy dropped without completion");
    AST_ZERO_IGNORED: assert property ((DST_WRITE_IN && !BUSY_OUT && PIXEL_COUNT_IN == '0) |=> !BUSY_OUT)
        else $error("Zero count started a move");
    AST_MASK_IN_MOVE: assert property ((SERIAL_CLOCK_MASK_OUT != 4'h0 || COLUMN_ADVANCE_ENABLE_OUT) |-> BUSY_OUT)
        else $error("Serial clock or column step outside a move");
    AST_ALIGNED_FULL: assert property ((aligned_reg && WR_VALID_OUT) |-> WR_ENABLE_OUT == 4'hF)
        else $error("Aligned move wrote a partial word");
    AST_HOLD_STALL: assert property ((HOLD_IN && BUSY_OUT) |=> SERIAL_CLOCK_MASK_OUT == 4'h0)
        else $error("Serial clock stepped during hold");
endmodule : bbms_sequencer_assertions
bind bbms_sequencer bbms_sequencer_assertions #(.CNT_W(CNT_W)) chk_u (.MCLK_IN, .RST_IN, .SRC_LSB_IN,
    .DST_LSB_IN, .PIXEL_COUNT_IN, .DST_WRITE_IN, .HOLD_IN, .BUSY_OUT, .DONE_OUT, .SHIFT_OUT,
    .SERIAL_CLOCK_MASK_OUT, .COLUMN_ADVANCE_ENABLE_OUT, .WR_ENABLE_OUT, .WR_VALID_OUT);
`default_nettype wire

//--- bbms_memory_model.sv
/*
 * Behavioural frame buffer memory: serial buffer lanes and random port readiness.
 * Assumes the serial buffer was loaded word-aligned before the move starts.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory model
module bbms_memory_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       load_in,
    input  wire logic       slow_in,
    input  wire logic [3:0] serial_clock_mask_in,
    output logic [31:0]     serial_data_out,
    output logic            wr_ready_out
);
    logic [7:0] lane_ptr [4];
    logic       toggle;
    // Each lane has its own pointer; a masked clock leaves that pixel in place.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) lane_ptr[i] <= 8'h00;
            toggle <= 1'b0;
        end else if (load_in) begin
            // A read transfer puts every lane back on the word holding the first source pixel.
            for (int i = 0; i < 4; i++) lane_ptr[i] <= 8'h00;
            toggle <= ~toggle;
        end else begin
            for (int i = 0; i < 4; i++) if (serial_clock_mask_in[3-i]) lane_ptr[i] <= lane_ptr[i] + 8'h04;
            toggle <= ~toggle;
        end
    end
    // Pixel 0 sits in the top byte of the word.
    assign serial_data_out = {lane_ptr[0], lane_ptr[1] + 8'h01, lane_ptr[2] + 8'h02, lane_ptr[3] + 8'h03};
    // A slow memory takes a write only every other cycle, as when refresh steals the port.
    assign wr_ready_out = !slow_in || toggle;
endmodule : bbms_memory_model
`default_nettype wire

//--- tb.sv
/*
 * Self-checking testbench for the pixel block move sequencer.
 * Assumes the design, the checker and the memory model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Testbench
module tb;
    logic        clk, rst, go, load, hold, slow, rdy, busy, done, cae, wvalid;
    logic [31:0] wdata;
    logic [31:0] dq[$];
    logic [1:0]  src, dst, shift;
    logic [19:0] cnt;
    logic [31:0] sdata;
    logic [3:0]  scm, wen;
    logic [3:0]  wq[$], sq[$];
    logic        cq[$];
    int          fails, n_tests;
    bbms_sequencer #(.CNT_W(20)) dut_u (.MCLK_IN(clk), .RST_IN(rst), .SRC_LSB_IN(src), .DST_LSB_IN(dst),
        .PIXEL_COUNT_IN(cnt), .DST_WRITE_IN(go), .HOLD_IN(hold), .SERIAL_DATA_IN(sdata), .WR_READY_IN(rdy),
        .BUSY_OUT(busy), .DONE_OUT(done), .SHIFT_OUT(shift), .SERIAL_CLOCK_MASK_OUT(scm),
        .COLUMN_ADVANCE_ENABLE_OUT(cae), .WR_DATA_OUT(wdata), .WR_ENABLE_OUT(wen), .WR_VALID_OUT(wvalid));
    bbms_memory_model mem_u (.clk_in(clk), .rst_in(rst), .load_in(load), .slow_in(slow), .serial_clock_mask_in(scm),
        .serial_data_out(sdata), .wr_ready_out(rdy));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wvalid === 1'b1) begin
            wq.push_back(wen);
            dq.push_back(wdata);
        end
        if (scm !== 4'h0) begin
            sq.push_back(scm);
            cq.push_back(cae);
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic wait_ev(input logic want_done);
        int i;
        for (i = 0; i < 500 && (want_done ? done !== 1'b1 : busy !== 1'b1); i++) @(posedge clk);
        if (i == 500) begin
            chk("wait for sequencer", 8'h01, 8'h00);
            summarize();
        end
    endtask : wait_ev
    task automatic move(input int s, input int d, input int n, input logic slw, input logic hld, input logic poke);
        logic [3:0] e1, c1, e2, c2, ee;
        int words;
        wq.delete();
        sq.delete();
        cq.delete();
        dq.delete();
        e1 = 4'h0;
        for (int p = 0; p < 4; p++) if (p >= d && p <= d + 3 - s) e1[3-p] = 1'b1;
        c1 = (s >= d) ? 4'hF : 4'(4'hF << (d - s));
        e2 = (s > d) ? 4'(4'hF >> (4 - (s - d))) : 4'hF;
        c2 = (s > d) ? ~4'(4'hF >> (s - d)) : 4'hF;
        ee = 4'(4'hF << (4 - (((d + n - 1) % 4) + 1)));
        words = ((d + n - 1) / 4) + 1 + ((s > d) ? 1 : 0);
        src <= 2'(s);
        dst <= 2'(d);
        cnt <= 20'(n);
        slow <= slw;
        load <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        go <= 1'b0;
        hold <= hld;
        wait_ev(1'b0);
        chk("shift", 8'((s - d) & 3), {6'h0, shift});
        if (poke) begin
            src <= 2'(s + 1);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
        end
        repeat (3) @(posedge clk);
        hold <= 1'b0;
        wait_ev(1'b1);
        repeat (16) @(posedge clk);
        chk("write count", 8'(words), 8'(wq.size()));
        foreach (dq[i]) for (int p = 0; p < 4; p++) if (wq[i][3-p])
            chk("write data", 8'(4 * ((s > d && i > 0) ? i - 1 : i) + p - d + s), dq[i][31-8*p -: 8]);
        if (wq.size() < 3 || sq.size() < 2) return;
        chk("first write enable", {4'h0, e1}, {4'h0, wq[0]});
        chk("first clock mask", {4'h0, c1}, {4'h0, sq[0]});
        chk("first column step", {7'h0, s <= d}, {7'h0, cq[0]});
        chk("second write enable", {4'h0, e2}, {4'h0, wq[1]});
        chk("second clock mask", {4'h0, c2}, {4'h0, sq[1]});
        chk("second column step", 8'h01, {7'h0, cq[1]});
        for (int i = 2; i < wq.size() - 1; i++) chk("middle write enable", 8'h0F, {4'h0, wq[i]});
        chk("ending write enable", {4'h0, ee}, {4'h0, wq[wq.size()-1]});
        if (s == 0 && d == 0 && n % 4 == 0) foreach (sq[i]) chk("aligned clock mask", 8'h0F, {4'h0, sq[i]});
    endtask : move
    initial begin
        {go, load, hold, slow, src, dst, cnt} = '0;
        rst = 1'b1;
        fails = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("outputs after reset", 8'h00, {busy, done, cae, wvalid, wen});
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        chk("busy after zero count", 8'h00, {7'h0, busy});
        for (int s = 0; s < 4; s++) for (int d = 0; d < 4; d++) for (int c = 0; c < 4; c++)
            move(s, d, 29 + c, c == 1, c == 2, s == 1 && d == 2 && c == 0);
        summarize();
    end
endmodule : tb
`default_nettype wire
